// file: hw/dxj_decode.sv
// Purpose: combinational opcode classifier for the execute block
// Assumes: instruction word is stable while valid
// Notes: branch class is an input since other branch encodings lie outside this block
`timescale 1ns/1ps
module dxj_decode (
  input wire logic [15:0] instr,
  output logic is_dec_test,
  output logic is_sext_b,
  output logic is_sext_w,
  output logic is_zext_b,
  output logic is_zext_w,
  output logic is_ind_jump,
  output logic is_jump_sub,
  output logic [3:0] dst_idx,
  output logic [3:0] src_idx
);
  // ---------------------------------------------------------------
  // opcode match
  // ---------------------------------------------------------------
  always_comb begin
    is_dec_test = (instr & dxj_pkg::MASK_ONE_REG) == dxj_pkg::OP_DEC_TEST;
    is_sext_b = (instr & dxj_pkg::MASK_TWO_REG) == dxj_pkg::OP_SEXT_B;
    is_sext_w = (instr & dxj_pkg::MASK_TWO_REG) == dxj_pkg::OP_SEXT_W;
    is_zext_b = (instr & dxj_pkg::MASK_TWO_REG) == dxj_pkg::OP_ZEXT_B;
    is_zext_w = (instr & dxj_pkg::MASK_TWO_REG) == dxj_pkg::OP_ZEXT_W;
    is_ind_jump = (instr & dxj_pkg::MASK_ONE_REG) == dxj_pkg::OP_IND_JUMP;
    is_jump_sub = (instr & dxj_pkg::MASK_ONE_REG) == dxj_pkg::OP_JUMP_SUB;
    // jumps name their address register in the upper field
    dst_idx = instr[dxj_pkg::DST_HI:dxj_pkg::DST_LO];
    src_idx = instr[dxj_pkg::SRC_HI:dxj_pkg::SRC_LO];
  end
endmodule // dxj_decode

// file: hw/dxj_exec.sv
// Purpose: execute stage for decrement-test, extends and register-indirect jumps
// Assumes: register reads are combinational on the index outputs; one instruction per cycle
// Notes: jumps are delayed; the slot instruction runs before the transfer
`timescale 1ns/1ps
// Functional notes
// - decrement register, write back, flag on zero
// - byte sign extend from bit seven
// - word sign extend from bit fifteen
// - byte zero extend, clear upper bits
// - word zero extend, clear upper bits
// - jump loads full register, two cycles
// - subroutine jump saves address plus four
// - both jumps run one slot instruction
// - hold interrupts and address errors over slot
// - branch in slot flagged illegal
module dxj_exec (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic instr_is_branch,
  output logic [3:0] rd_a_idx,
  output logic [3:0] rd_b_idx,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  input wire logic irq_req,
  input wire logic addr_err_req,
  output dxj_pkg::dxj_wr_s reg_wr,
  output logic test_flag_we,
  output logic test_flag,
  output dxj_pkg::dxj_redirect_s pc_redirect,
  output logic ret_addr_we,
  output logic [31:0] return_address_register,
  output logic event_hold,
  output logic irq_take,
  output logic addr_err_take,
  output logic illegal_slot,
  output logic in_slot
);
  logic is_dt, is_sb, is_sw, is_zb, is_zw, is_jmp, is_jsr;
  logic [3:0] dst_idx, src_idx;
  logic [31:0] dec_val;
  logic [31:0] jump_target_r;
  logic [31:0] jump_target_nxt;
  logic slot_ok;
  dxj_pkg::dxj_state_e state_r;

  dxj_decode u_decode (
    .instr(instr),
    .is_dec_test(is_dt),
    .is_sext_b(is_sb),
    .is_sext_w(is_sw),
    .is_zext_b(is_zb),
    .is_zext_w(is_zw),
    .is_ind_jump(is_jmp),
    .is_jump_sub(is_jsr),
    .dst_idx(dst_idx),
    .src_idx(src_idx)
  );

  // ---------------------------------------------------------------
  // operand fetch
  // ---------------------------------------------------------------
  // port a reads the upper field (destination, or jump address reg)
  assign rd_a_idx = dst_idx;
  assign rd_b_idx = src_idx;
  assign dec_val = rd_a_data - dxj_pkg::ONE;
  // target latched at issue so a slot write to the register cannot move it
  assign jump_target_nxt = rd_a_data;
  // a branch in the slot is refused as illegal and does no work
  assign slot_ok = !(state_r == dxj_pkg::DXJ_SLOT && instr_is_branch);

  // ---------------------------------------------------------------
  // delay-slot sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= dxj_pkg::DXJ_IDLE;
      jump_target_r <= dxj_pkg::ZERO;
    end else begin
      case (state_r)
        dxj_pkg::DXJ_IDLE: begin
          if (instr_valid && (is_jmp || is_jsr)) begin
            state_r <= dxj_pkg::DXJ_SLOT;
            jump_target_r <= jump_target_nxt;
          end
        end
        dxj_pkg::DXJ_SLOT: begin
          // transfer happens as the slot completes: second cycle of the jump
          if (instr_valid) begin
            state_r <= dxj_pkg::DXJ_IDLE;
          end
        end
        default: state_r <= dxj_pkg::DXJ_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register write-back and test flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_wr <= '0;
      test_flag_we <= 1'b0;
      test_flag <= 1'b0;
    end else begin
      reg_wr.valid <= 1'b0;
      test_flag_we <= 1'b0;
      if (instr_valid && slot_ok) begin
        reg_wr.idx <= dst_idx;
        if (is_dt) begin
          reg_wr.valid <= 1'b1;
          reg_wr.data <= dec_val;
          test_flag_we <= 1'b1;
          test_flag <= (dec_val == dxj_pkg::ZERO);
        end else if (is_sb) begin
          reg_wr.valid <= 1'b1;
          reg_wr.data <= {{(dxj_pkg::XLEN-dxj_pkg::BYTE_W){rd_b_data[dxj_pkg::BYTE_W-1]}},
                          rd_b_data[dxj_pkg::BYTE_W-1:0]};
        end else if (is_sw) begin
          reg_wr.valid <= 1'b1;
          reg_wr.data <= {{(dxj_pkg::XLEN-dxj_pkg::WORD_W){rd_b_data[dxj_pkg::WORD_W-1]}},
                          rd_b_data[dxj_pkg::WORD_W-1:0]};
        end else if (is_zb) begin
          reg_wr.valid <= 1'b1;
          reg_wr.data <= {{(dxj_pkg::XLEN-dxj_pkg::BYTE_W){1'b0}},
                          rd_b_data[dxj_pkg::BYTE_W-1:0]};
        end else if (is_zw) begin
          reg_wr.valid <= 1'b1;
          reg_wr.data <= {{(dxj_pkg::XLEN-dxj_pkg::WORD_W){1'b0}},
                          rd_b_data[dxj_pkg::WORD_W-1:0]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // return address
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ret_addr_we <= 1'b0;
      return_address_register <= dxj_pkg::ZERO;
    end else begin
      ret_addr_we <= 1'b0;
      if (instr_valid && state_r == dxj_pkg::DXJ_IDLE && is_jsr) begin
        ret_addr_we <= 1'b1;
        return_address_register <= instr_addr + dxj_pkg::RET_OFFSET;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter redirect
  // ---------------------------------------------------------------
  // issued only after the slot, so the target is never the slot's address
  // an illegal slot cancels the transfer: the slot fault takes over instead
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pc_redirect <= '0;
    end else begin
      pc_redirect.valid <= 1'b0;
      if (instr_valid && state_r == dxj_pkg::DXJ_SLOT && slot_ok) begin
        pc_redirect.valid <= 1'b1;
        pc_redirect.target <= jump_target_r;
      end
    end
  end

  // ---------------------------------------------------------------
  // event gating and slot status
  // ---------------------------------------------------------------
  // requests are levels held by their sources, so holding them off loses nothing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      event_hold <= 1'b0;
      irq_take <= 1'b0;
      addr_err_take <= 1'b0;
      illegal_slot <= 1'b0;
      in_slot <= 1'b0;
    end else begin
      event_hold <= (state_r == dxj_pkg::DXJ_SLOT) ||
                    (instr_valid && (is_jmp || is_jsr));
      irq_take <= irq_req && state_r == dxj_pkg::DXJ_IDLE &&
                  !(instr_valid && (is_jmp || is_jsr));
      addr_err_take <= addr_err_req && state_r == dxj_pkg::DXJ_IDLE &&
                       !(instr_valid && (is_jmp || is_jsr));
      illegal_slot <= instr_valid && !slot_ok;
      in_slot <= state_r == dxj_pkg::DXJ_SLOT;
    end
  end
endmodule // dxj_exec

// file: hw/dxj_pkg.sv
// Purpose: shared constants and carriers for the decrement/extend/jump execute block
// Assumes: 16-bit instruction words, 32-bit data path
// Notes: opcode masks and match values hold every fixed bit of each encoding
package dxj_pkg;
  localparam int XLEN = 32;
  localparam int ILEN = 16;
  localparam int RIDX = 4;
  // register index field positions
  localparam int DST_HI = 11;
  localparam int DST_LO = 8;
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 4;
  // sign bit positions and extension widths
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  // opcode masks and matches
  localparam logic [15:0] MASK_ONE_REG = 16'hF0FF;
  localparam logic [15:0] MASK_TWO_REG = 16'hF00F;
  localparam logic [15:0] OP_DEC_TEST = 16'h4010;
  localparam logic [15:0] OP_SEXT_B = 16'h600E;
  localparam logic [15:0] OP_SEXT_W = 16'h600F;
  localparam logic [15:0] OP_ZEXT_B = 16'h600C;
  localparam logic [15:0] OP_ZEXT_W = 16'h600D;
  localparam logic [15:0] OP_IND_JUMP = 16'h402B;
  localparam logic [15:0] OP_JUMP_SUB = 16'h400B;
  // return address offset from the jump instruction
  localparam logic [31:0] RET_OFFSET = 32'h0000_0004;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  // jump takes two cycles: issue and transfer
  localparam int JUMP_CYCLES = 2;

  typedef enum logic [1:0] {
    DXJ_IDLE = 2'b01,
    DXJ_SLOT = 2'b10
  } dxj_state_e;

  // register-file write port bundle
  typedef struct packed {
    logic valid;
    logic [RIDX-1:0] idx;
    logic [XLEN-1:0] data;
  } dxj_wr_s;

  // program-counter redirect bundle
  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] target;
  } dxj_redirect_s;
endpackage

// file: tb/dxj_exec_bench.sv
// Purpose: self-checking bench for the decrement/extend/jump execute block
// Assumes: bench plays fetch, register file and event sources
// Notes: register file is stimulus only; design writes are compared, not stored
`timescale 1ns/1ps
module dxj_exec_bench;
  // ----------
  // harness
  // ----------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0009;
  logic [31:0] instr_addr = 32'h0000_1000;
  logic instr_is_branch = 1'b0;
  logic irq_req = 1'b0;
  logic addr_err_req = 1'b0;
  logic [31:0] rf [16];
  logic [3:0] rd_a_idx, rd_b_idx;
  dxj_pkg::dxj_wr_s reg_wr;
  dxj_pkg::dxj_redirect_s pc_redirect;
  logic test_flag_we, test_flag, ret_addr_we, event_hold, irq_take, addr_err_take, illegal_slot;
  logic [31:0] ret_addr;
  logic in_slot;
  int fails = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  dxj_exec uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .instr_addr(instr_addr), .instr_is_branch(instr_is_branch), .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx), .rd_a_data(rf[rd_a_idx]), .rd_b_data(rf[rd_b_idx]), .irq_req(irq_req),
    .addr_err_req(addr_err_req), .reg_wr(reg_wr), .test_flag_we(test_flag_we),
    .test_flag(test_flag), .pc_redirect(pc_redirect), .ret_addr_we(ret_addr_we),
    .return_address_register(ret_addr), .event_hold(event_hold), .irq_take(irq_take),
    .addr_err_take(addr_err_take), .illegal_slot(illegal_slot), .in_slot(in_slot));
  // value and flag compares
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // one instruction per call; address steps by one halfword
  task automatic send(input logic [15:0] op, input logic br);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= op;
    instr_is_branch <= br;
    instr_addr <= instr_addr + 32'h2;
  endtask
  // bubble, then let the edge's updates land before looking
  task automatic idle;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr_is_branch <= 1'b0;
    #1;
  endtask
  // expected extend results, worked out bit by bit
  function automatic logic [31:0] ext(input logic [3:0] k, input logic [31:0] s);
    case (k)
      4'hC: return {24'h0, s[7:0]};
      4'hD: return {16'h0, s[15:0]};
      4'hE: return {{24{s[7]}}, s[7:0]};
      default: return {{16{s[15]}}, s[15:0]};
    endcase
  endfunction
  // ----------
  // scenarios
  // ----------
  // decrement through one, two and the wrap from zero
  task automatic t_dt;
    logic [31:0] v [3] = '{32'h1, 32'h2, 32'h0};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rf[5] <= v[i];
      send(16'h4510, 1'b0);
      idle();
      chk({28'h0, reg_wr.idx}, 32'h5);
      chk(reg_wr.data, v[i] - 32'h1);
      chkb(test_flag, v[i] == 32'h1);
      chkb(test_flag_we, 1'b1);
    end
  endtask
  // all four extends, each with sign bits set and clear
  task automatic t_ext;
    logic [31:0] v [2] = '{32'hFFFF_8080, 32'h0000_7F7F};
    for (int k = 12; k < 16; k++) begin
      for (int j = 0; j < 2; j++) begin
        @(posedge clk);
        rf[3] <= v[j];
        send({12'h613, 4'(k)}, 1'b0);
        idle();
        chkb(reg_wr.valid, 1'b1);
        chk(reg_wr.data, ext(4'(k), v[j]));
      end
    end
  endtask
  // jump with events pending; slot rewrites the address register
  task automatic t_jump(input logic [15:0] op, input logic [15:0] slot, input logic sbr);
    logic [31:0] a;
    @(posedge clk);
    rf[4] <= 32'h8000_0120;
    a = instr_addr + 32'h2;
    send(op, 1'b1);
    irq_req <= 1'b1;
    addr_err_req <= 1'b1;
    send(slot, sbr);
    rf[4] <= 32'h0000_0BAD;
    #1;
    chkb(pc_redirect.valid, 1'b0);
    chkb(event_hold, 1'b1);
    chkb(irq_take | addr_err_take, 1'b0);
    if (op[5] == 1'b0) chk(ret_addr, a + 32'h4);
    idle();
    chkb(in_slot, 1'b1);
    chkb(illegal_slot, sbr);
    chkb(pc_redirect.valid, !sbr);
    if (!sbr) chk(pc_redirect.target, 32'h8000_0120);
    chkb(irq_take | addr_err_take, 1'b0);
    for (int i = 0; i < 8 && (irq_take | addr_err_take) !== 1'b1; i++) idle();
    chkb(irq_take | addr_err_take, 1'b1);
    @(posedge clk);
    irq_req <= 1'b0;
    addr_err_req <= 1'b0;
    repeat (3) idle();
  endtask
  // ----------
  // run control
  // ----------
  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence: reset for eight cycles, then every scenario
  initial begin
    for (int i = 0; i < 16; i++) rf[i] = 32'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_dt();
    t_ext();
    t_jump(16'h440B, 16'h4410, 1'b0);
    t_jump(16'h442B, 16'h4410, 1'b0);
    t_jump(16'h442B, 16'hA000, 1'b1);
    t_jump(16'h440B, 16'h442B, 1'b1);
    conclude();
  end
  // watchdog: the whole run needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule // dxj_exec_bench

// file: tb/dxj_exec_monitor.sv
// Purpose: port checker for the decrement/extend/jump execute block
// Assumes: one clock, synchronous active-low reset
// Notes: jump antecedents skip slot cycles by looking at event_hold
`timescale 1ns/1ps
module dxj_exec_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_addr,
  input wire logic instr_is_branch,
  input wire logic [3:0] rd_a_idx,
  input wire logic [3:0] rd_b_idx,
  input wire logic [31:0] rd_a_data,
  input wire logic [31:0] rd_b_data,
  input wire dxj_pkg::dxj_wr_s reg_wr,
  input wire logic test_flag,
  input wire dxj_pkg::dxj_redirect_s pc_redirect,
  input wire logic ret_addr_we,
  input wire logic [31:0] return_address_register,
  input wire logic event_hold,
  input wire logic irq_take,
  input wire logic addr_err_take,
  input wire logic illegal_slot
);
  // ----------
  // decode helpers and properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] op1;
  logic [15:0] op2;
  logic ex;
  logic indirect_jump;
  // a jump seen inside a slot is not a fresh jump, so event_hold gates it
  assign op1 = instr & dxj_pkg::MASK_ONE_REG;
  assign op2 = instr & dxj_pkg::MASK_TWO_REG;
  assign ex = instr_valid && !instr_is_branch;
  assign indirect_jump = instr_valid && !event_hold &&
               (op1 == dxj_pkg::OP_IND_JUMP || op1 == dxj_pkg::OP_JUMP_SUB);
  a_reg_fields: assert property (rd_a_idx == instr[11:8] && rd_b_idx == instr[7:4])
    else $error("register index fields wrong");
  a_dec_test: assert property (ex && op1 == dxj_pkg::OP_DEC_TEST |=> reg_wr.valid &&
    reg_wr.data == $past(rd_a_data) - dxj_pkg::ONE &&
    test_flag == ($past(rd_a_data) == dxj_pkg::ONE))
    else $error("decrement result or flag wrong");
  a_sext_byte: assert property (ex && op2 == dxj_pkg::OP_SEXT_B |=>
    reg_wr.data == {{24{$past(rd_b_data[7])}}, $past(rd_b_data[7:0])})
    else $error("byte sign extend");
  a_zext_word: assert property (ex && op2 == dxj_pkg::OP_ZEXT_W |=>
    reg_wr.data == {16'h0000, $past(rd_b_data[15:0])}) else $error("word zero extend wrong");
  a_jsr_return: assert property (indirect_jump && op1 == dxj_pkg::OP_JUMP_SUB |=> ret_addr_we &&
    return_address_register == $past(instr_addr) + dxj_pkg::RET_OFFSET)
    else $error("return address");
  a_jump_delayed: assert property (indirect_jump |=> !pc_redirect.valid && event_hold)
    else $error("jump transferred before its slot");
  a_jump_target: assert property (indirect_jump ##1 ex |=> pc_redirect.valid &&
    pc_redirect.target == $past(rd_a_data, 2)) else $error("jump target wrong");
  a_slot_illegal: assert property (indirect_jump ##1 (instr_valid && instr_is_branch) |=>
    illegal_slot && !pc_redirect.valid) else $error("branch in slot not flagged");
  a_events_held: assert property (event_hold |-> !irq_take && !addr_err_take)
    else $error("event taken inside jump pair");
  // both the jump edge and the slot edge must leave pending events waiting
  a_pair_events: assert property (indirect_jump |=> (!irq_take && !addr_err_take) [*2])
    else $error("event taken before slot completed");
endmodule // dxj_exec_monitor

bind dxj_exec dxj_exec_monitor mon (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
  .instr(instr), .instr_addr(instr_addr), .instr_is_branch(instr_is_branch), .rd_a_idx(rd_a_idx),
  .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .reg_wr(reg_wr),
  .test_flag(test_flag), .pc_redirect(pc_redirect), .ret_addr_we(ret_addr_we),
  .return_address_register(return_address_register), .event_hold(event_hold),
  .irq_take(irq_take), .addr_err_take(addr_err_take), .illegal_slot(illegal_slot));
